/* hdl/ssc_pkg.sv */
package ssc_pkg;

    // Register field positions
    localparam int unsigned SSC_BIT_ABORT_WR = 5;
    localparam int unsigned SSC_BIT_FAST_WR  = 4;
    localparam int unsigned SSC_BIT_ABORT_RT = 3;
    localparam int unsigned SSC_BIT_FIQ      = 2;
    localparam int unsigned SSC_BIT_IRQ      = 1;
    localparam int unsigned SSC_BIT_NONSEC   = 0;
    localparam int unsigned SSC_FIELD_W      = 6;

    // Value after reset and writable mask
    localparam logic [31:0] SSC_RESET_VALUE = 32'h0000_0000;
    localparam logic [31:0] SSC_WRITE_MASK  = 32'h0000_003F;
    localparam logic        SSC_ALLOW_RESET = 1'b1;

    // Coprocessor move encoding of the register
    localparam logic [3:0] SSC_CP_NUM = 4'hF;
    localparam logic [2:0] SSC_OPC1   = 3'h0;
    localparam logic [3:0] SSC_CRN    = 4'h1;
    localparam logic [3:0] SSC_CRM    = 4'h1;
    localparam logic [2:0] SSC_OPC2   = 3'h0;

    // Exception entry targets
    typedef enum logic [2:0] {
        SSC_MODE_NONE    = 3'b000,
        SSC_MODE_ABORT   = 3'b001,
        SSC_MODE_FIQ     = 3'b010,
        SSC_MODE_IRQ     = 3'b011,
        SSC_MODE_MONITOR = 3'b100
    } ssc_mode_e;

endpackage

/* hdl/ssc_exc_router.sv */
module ssc_exc_router
    import ssc_pkg::*;
(
    input  wire logic            sys_clk_i,
    input  wire logic            reset_n_i,
    input  wire logic            abort_rt_i,
    input  wire logic            fiq_rt_i,
    input  wire logic            irq_rt_i,
    input  wire logic            ext_abort_i,
    input  wire logic            fiq_req_i,
    input  wire logic            irq_req_i,
    output ssc_mode_e            entry_mode_o,
    output logic                 entry_valid_o,
    output logic                 fault_secure_o
);

    ssc_mode_e mode_reg;
    ssc_mode_e mode_next;
    logic      valid_reg;
    logic      valid_next;
    logic      fsec_reg;
    logic      fsec_next;

    // Abort first, then fast, then normal interrupt
    always_comb begin
        mode_next  = SSC_MODE_NONE;
        valid_next = 1'b0;
        fsec_next  = 1'b0;
        if (ext_abort_i) begin
            valid_next = 1'b1;
            mode_next  = abort_rt_i ? SSC_MODE_MONITOR : SSC_MODE_ABORT;
            fsec_next  = abort_rt_i;
        end else if (fiq_req_i) begin
            valid_next = 1'b1;
            mode_next  = fiq_rt_i ? SSC_MODE_MONITOR : SSC_MODE_FIQ;
        end else if (irq_req_i) begin
            valid_next = 1'b1;
            mode_next  = irq_rt_i ? SSC_MODE_MONITOR : SSC_MODE_IRQ;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_reg  <= SSC_MODE_NONE;
            valid_reg <= 1'b0;
            fsec_reg  <= 1'b0;
        end else begin
            mode_reg  <= mode_next;
            valid_reg <= valid_next;
            fsec_reg  <= fsec_next;
        end
    end

    assign entry_mode_o   = mode_reg;
    assign entry_valid_o  = valid_reg;
    assign fault_secure_o = fsec_reg;

endmodule

/* hdl/ssc_secure_config.sv */
// Summary of operation
// - Abort mask bit five gates nonsecure changes
// - Fast mask bit four gates nonsecure changes
// - Bit three sends external aborts to monitor
// - Monitor-taken aborts log into secure fault copies
// - Bit two sends fast interrupts to monitor
// - Bit one sends normal interrupts to monitor
// - Bit zero outside monitor gives security state
// - Bit zero in monitor picks banked view
// - Fast mask and routing pairs select handling; here bit two alone picks the entry
// - Abort mask and routing pairs select handling; here bit three alone picks the entry
// - Reached by coprocessor 15, 0, c1, c1, 0
// - Non secure-privileged access raises undefined exception
module ssc_secure_config
    import ssc_pkg::*;
(
    input  wire logic            sys_clk_i,
    input  wire logic            reset_n_i,
    input  wire logic            cp_req_i,
    input  wire logic            cp_write_i,
    input  wire logic [3:0]      cp_num_i,
    input  wire logic [2:0]      cp_opc1_i,
    input  wire logic [3:0]      cp_crn_i,
    input  wire logic [3:0]      cp_crm_i,
    input  wire logic [2:0]      cp_opc2_i,
    input  wire logic [31:0]     cp_wdata_i,
    input  wire logic            priv_mode_i,
    input  wire logic            monitor_mode_i,
    input  wire logic            ext_abort_i,
    input  wire logic            fiq_req_i,
    input  wire logic            irq_req_i,
    output logic                 cp_ack_o,
    output logic                 cp_undef_o,
    output logic [31:0]          cp_rdata_o,
    output logic                 nonsecure_state_o,
    output logic                 bank_view_nonsecure_o,
    output logic                 abort_mask_write_allow_o,
    output logic                 fast_irq_mask_write_allow_o,
    output ssc_mode_e            entry_mode_o,
    output logic                 entry_valid_o,
    output logic                 fault_secure_o
);

    ////////////////////////////////////////////////////////////////////
    // Configuration register
    logic [SSC_FIELD_W-1:0] secure_configuration_reg;
    logic [SSC_FIELD_W-1:0] secure_configuration_next;

    ////////////////////////////////////////////////////////////////////
    // Access response registers
    logic                   ack_reg;
    logic                   ack_next;
    logic                   undef_reg;
    logic                   undef_next;
    logic [31:0]            rdata_reg;
    logic [31:0]            rdata_next;

    ////////////////////////////////////////////////////////////////////
    // State and permission view registers
    logic                   nonsec_state_reg;
    logic                   nonsec_state_next;
    logic                   bank_nonsec_reg;
    logic                   bank_nonsec_next;
    logic                   abort_ok_reg;
    logic                   abort_ok_next;
    logic                   fast_ok_reg;
    logic                   fast_ok_next;

    ////////////////////////////////////////////////////////////////////
    // Access decode
    logic                   hit;
    logic                   secure_now;
    logic                   allowed;
    logic                   legal_write;
    logic                   legal_read;

    ////////////////////////////////////////////////////////////////////
    // Helper functions

    // Encoding match for this register
    function automatic logic ssc_decode(
        input logic [3:0] num,
        input logic [2:0] opc1,
        input logic [3:0] crn,
        input logic [3:0] crm,
        input logic [2:0] opc2
    );
        ssc_decode = (num == SSC_CP_NUM) && (opc1 == SSC_OPC1) &&
                     (crn == SSC_CRN) && (crm == SSC_CRM) &&
                     (opc2 == SSC_OPC2);
    endfunction

    // Mask change allowed when secure or write bit set
    function automatic logic ssc_mask_ok(
        input logic nonsec,
        input logic write_bit
    );
        ssc_mask_ok = !nonsec || write_bit;
    endfunction

    // Reserved bits read zero
    function automatic logic [31:0] ssc_read_word(
        input logic [SSC_FIELD_W-1:0] cfg
    );
        ssc_read_word = {{(32-SSC_FIELD_W){1'b0}}, cfg};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Coprocessor access decode
    always_comb begin
        hit         = cp_req_i &&
                      ssc_decode(cp_num_i, cp_opc1_i, cp_crn_i,
                                 cp_crm_i, cp_opc2_i);
        // Monitor mode is always secure
        secure_now  = monitor_mode_i ||
                      !secure_configuration_reg[SSC_BIT_NONSEC];
        allowed     = priv_mode_i && secure_now;
        legal_write = hit && allowed && cp_write_i;
        legal_read  = hit && allowed && !cp_write_i;
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration register update
    always_comb begin
        secure_configuration_next = secure_configuration_reg;
        if (legal_write) begin
            // Reserved bits write ignored
            secure_configuration_next =
                cp_wdata_i[SSC_FIELD_W-1:0] &
                SSC_WRITE_MASK[SSC_FIELD_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            secure_configuration_reg <= SSC_RESET_VALUE[SSC_FIELD_W-1:0];
        end else begin
            secure_configuration_reg <= secure_configuration_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Access response
    always_comb begin
        ack_next   = hit;
        undef_next = 1'b0;
        rdata_next = rdata_reg;
        if (hit && !allowed) begin
            undef_next = 1'b1;
            rdata_next = 32'h0000_0000;
        end else if (legal_read) begin
            rdata_next = ssc_read_word(secure_configuration_reg);
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_reg   <= 1'b0;
            undef_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= ack_next;
            undef_reg <= undef_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State and permission views
    always_comb begin
        nonsec_state_next = !monitor_mode_i &&
                            secure_configuration_next[SSC_BIT_NONSEC];
        bank_nonsec_next  = monitor_mode_i ?
                            secure_configuration_next[SSC_BIT_NONSEC] :
                            nonsec_state_next;
        abort_ok_next     = ssc_mask_ok(nonsec_state_next,
                                secure_configuration_next[SSC_BIT_ABORT_WR]);
        fast_ok_next      = ssc_mask_ok(nonsec_state_next,
                                secure_configuration_next[SSC_BIT_FAST_WR]);
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            nonsec_state_reg <= 1'b0;
            bank_nonsec_reg  <= 1'b0;
            abort_ok_reg     <= SSC_ALLOW_RESET;
            fast_ok_reg      <= SSC_ALLOW_RESET;
        end else begin
            nonsec_state_reg <= nonsec_state_next;
            bank_nonsec_reg  <= bank_nonsec_next;
            abort_ok_reg     <= abort_ok_next;
            fast_ok_reg      <= fast_ok_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign cp_ack_o                    = ack_reg;
    assign cp_undef_o                  = undef_reg;
    assign cp_rdata_o                  = rdata_reg;
    assign nonsecure_state_o           = nonsec_state_reg;
    assign bank_view_nonsecure_o       = bank_nonsec_reg;
    assign abort_mask_write_allow_o    = abort_ok_reg;
    assign fast_irq_mask_write_allow_o = fast_ok_reg;

    ////////////////////////////////////////////////////////////////////
    // Exception routing
    ssc_exc_router u_router (
        .sys_clk_i      (sys_clk_i),
        .reset_n_i      (reset_n_i),
        .abort_rt_i     (secure_configuration_reg[SSC_BIT_ABORT_RT]),
        .fiq_rt_i       (secure_configuration_reg[SSC_BIT_FIQ]),
        .irq_rt_i       (secure_configuration_reg[SSC_BIT_IRQ]),
        .ext_abort_i    (ext_abort_i),
        .fiq_req_i      (fiq_req_i),
        .irq_req_i      (irq_req_i),
        .entry_mode_o   (entry_mode_o),
        .entry_valid_o  (entry_valid_o),
        .fault_secure_o (fault_secure_o)
    );

endmodule

/* verif/ssc_secure_config_sva.sv */
module ssc_secure_config_chk
    import ssc_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        reset_n_i,
    input wire logic        cp_req_i,
    input wire logic [3:0]  cp_num_i,
    input wire logic [2:0]  cp_opc1_i,
    input wire logic [3:0]  cp_crn_i,
    input wire logic [3:0]  cp_crm_i,
    input wire logic [2:0]  cp_opc2_i,
    input wire logic        priv_mode_i,
    input wire logic        monitor_mode_i,
    input wire logic        ext_abort_i,
    input wire logic        cp_ack_o,
    input wire logic        cp_undef_o,
    input wire logic [31:0] cp_rdata_o,
    input wire logic        nonsecure_state_o,
    input wire logic        abort_mask_write_allow_o,
    input wire logic        fast_irq_mask_write_allow_o,
    input wire ssc_mode_e   entry_mode_o,
    input wire logic        entry_valid_o,
    input wire logic        fault_secure_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hit;
    assign hit = cp_req_i && cp_num_i == SSC_CP_NUM && cp_opc1_i == SSC_OPC1
        && cp_crn_i == SSC_CRN && cp_crm_i == SSC_CRM && cp_opc2_i == SSC_OPC2;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////
    chk_ack_on_hit: assert property (hit |=> cp_ack_o)
        else $error("ack missing");
    chk_no_stray_ack: assert property (!hit |=> !cp_ack_o)
        else $error("stray ack");
    chk_user_undef: assert property
        (hit && !priv_mode_i |=> cp_undef_o)
        else $error("user access not refused");
    chk_monitor_legal: assert property
        (hit && priv_mode_i && monitor_mode_i |=> !cp_undef_o)
        else $error("monitor access refused");
    chk_undef_zero: assert property
        (cp_undef_o |-> cp_rdata_o == 32'h0)
        else $error("refused read data not zero");
    chk_abort_route: assert property
        (ext_abort_i |=> entry_valid_o
        && fault_secure_o == (entry_mode_o == SSC_MODE_MONITOR)
        && entry_mode_o inside {SSC_MODE_ABORT, SSC_MODE_MONITOR})
        else $error("abort entry wrong");
    chk_secure_monitor: assert property
        (monitor_mode_i |=> !nonsecure_state_o)
        else $error("state not secure in monitor");
    chk_allow_secure: assert property (!nonsecure_state_o |->
        abort_mask_write_allow_o && fast_irq_mask_write_allow_o)
        else $error("mask change blocked in secure state");
    cover property (cp_ack_o && !cp_undef_o);
    cover property (cp_undef_o);
    cover property (fault_secure_o);
endmodule
bind ssc_secure_config ssc_secure_config_chk u_chk (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cp_req_i(cp_req_i),
    .cp_num_i(cp_num_i), .cp_opc1_i(cp_opc1_i), .cp_crn_i(cp_crn_i),
    .cp_crm_i(cp_crm_i), .cp_opc2_i(cp_opc2_i), .priv_mode_i(priv_mode_i),
    .monitor_mode_i(monitor_mode_i), .ext_abort_i(ext_abort_i),
    .cp_ack_o(cp_ack_o), .cp_undef_o(cp_undef_o), .cp_rdata_o(cp_rdata_o),
    .nonsecure_state_o(nonsecure_state_o),
    .abort_mask_write_allow_o(abort_mask_write_allow_o),
    .fast_irq_mask_write_allow_o(fast_irq_mask_write_allow_o),
    .entry_mode_o(entry_mode_o), .entry_valid_o(entry_valid_o),
    .fault_secure_o(fault_secure_o));

/* verif/tb.sv */
module tb
    import ssc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [17:0] REG_ENC =
        {SSC_CP_NUM, SSC_OPC1, SSC_CRN, SSC_CRM, SSC_OPC2};
    logic        sys_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        req = 1'b0, wr = 1'b0, pr = 1'b0, mn = 1'b0;
    logic [2:0]  evt = 3'h0;
    logic [17:0] enc = 18'h0;
    logic [31:0] wd = 32'h0, r, rd;
    logic [5:0]  mdl = 6'h0;
    logic        ack, und, nonsec, bank, abort_ok, fast_ok, vld, flt;
    ssc_mode_e   mode;
    logic [40:0] exp_q[$];
    logic [3:0]  ev_q[$];
    int          mismatches = 0, check_count = 0;
    ssc_secure_config DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .cp_req_i(req), .cp_write_i(wr), .cp_num_i(enc[17:14]),
        .cp_opc1_i(enc[13:11]), .cp_crn_i(enc[10:7]), .cp_crm_i(enc[6:3]),
        .cp_opc2_i(enc[2:0]), .cp_wdata_i(wd), .priv_mode_i(pr),
        .monitor_mode_i(mn), .ext_abort_i(evt[2]), .fiq_req_i(evt[1]),
        .irq_req_i(evt[0]), .cp_ack_o(ack), .cp_undef_o(und),
        .cp_rdata_o(rd), .nonsecure_state_o(nonsec),
        .bank_view_nonsecure_o(bank),
        .abort_mask_write_allow_o(abort_ok),
        .fast_irq_mask_write_allow_o(fast_ok),
        .entry_mode_o(mode), .entry_valid_o(vld), .fault_secure_o(flt));
    initial forever #50 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////
    task chk(input bit ok);
        check_count++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED at %0t: output mismatch", $time);
        end
    endtask
    task tally_and_finish;
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Software keeps both mask and routing pairs apart
    function automatic logic [31:0] safe_cfg(input logic [31:0] d);
        safe_cfg = {d[31:6], ~d[3], ~d[2], d[3:0]};
    endfunction
    task access(input bit w, p, m, input [31:0] d, input [17:0] e);
        bit ok;
        @(posedge sys_clk_i);
        {req, wr, pr, mn, wd, enc} <= {1'b1, w, p, m, d, e};
        ok = p && (m || !mdl[0]);
        if (e == REG_ENC) begin
            if (ok && w) mdl = d[5:0];
            exp_q.push_back({!(ok && w), !ok, m, mdl,
                (ok && !w) ? {26'h0, mdl} : 32'h0});
        end
        @(posedge sys_clk_i);
        req <= 1'b0;
    endtask
    task events(input [2:0] v);
        ssc_mode_e t;
        @(posedge sys_clk_i);
        evt <= v;
        t = mdl[1] ? SSC_MODE_MONITOR : SSC_MODE_IRQ;
        if (v[1]) t = mdl[2] ? SSC_MODE_MONITOR : SSC_MODE_FIQ;
        if (v[2]) t = mdl[3] ? SSC_MODE_MONITOR : SSC_MODE_ABORT;
        if (v != 3'h0) ev_q.push_back({v[2] & mdl[3], t});
        @(posedge sys_clk_i);
        evt <= 3'h0;
    endtask
    always @(negedge sys_clk_i) begin
        logic [40:0] n;
        if (ack === 1'b1) begin
            chk(exp_q.size() > 0);
            n = exp_q.pop_front();
            chk(und === n[39]);
            if (n[40]) chk(rd === n[31:0]);
            chk(nonsec === (n[32] & !n[38]));
            chk(abort_ok === (!(n[32] & !n[38]) | n[37]));
            chk(fast_ok === (!(n[32] & !n[38]) | n[36]));
            chk(bank === n[32]);
        end
        if (vld === 1'b1) begin
            chk(ev_q.size() > 0);
            chk({flt, mode} === ev_q.pop_front());
        end
    end
    initial begin
        void'($urandom(56));
        repeat (2) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        access(0, 1, 0, 32'h0, REG_ENC);
        for (int i = 0; i < 40; i++) begin
            r = $urandom;
            access(1, 1, 1, safe_cfg($urandom), REG_ENC);
            access(0, 1, 1, 32'h0, REG_ENC);
            events(r[2:0]);
            access(1, 1, r[3], $urandom,
                   REG_ENC ^ (18'h1 << (r[14:10] % 18)));
            access(r[7], r[8], r[9], safe_cfg($urandom),
                   REG_ENC);
        end
        for (int k = 0; k < 20 && exp_q.size() + ev_q.size() > 0; k++)
            @(posedge sys_clk_i);
        chk(exp_q.size() + ev_q.size() == 0);
        tally_and_finish();
    end
endmodule
